// ===== cdp_pkg.sv
// Constants and carrier types for the clock divider and prescaler block
package cdp_pkg;
   // Core clock rate, in MHz
   localparam int CORE_CLK_MHZ = 125;
   // Duty adjustment applies only when the oscillator is at or above this rate
   localparam int DUTY_MIN_FREQ_MHZ = 5;
   // Longest oscillator period in core cycles that still counts as 5 MHz or more
   localparam int DUTY_MAX_PERIOD_CYC = CORE_CLK_MHZ / DUTY_MIN_FREQ_MHZ;
   // External clock settling interval before the output is trusted
   localparam int EXT_CLOCK_SETTLE_TIME_US = 500;
   localparam int EXT_CLOCK_SETTLE_CYC = EXT_CLOCK_SETTLE_TIME_US * CORE_CLK_MHZ;
   // Division control register layout
   localparam logic [7:0] DCR_RESET = 8'hfc;
   localparam logic [7:0] DCR_FIXED_ONES = 8'hfc;
   localparam int DCR_RATIO_LSB = 0;
   localparam int DCR_RATIO_W = 2;
   // Prescaler chain depth: taps at /2 up to /4096
   localparam int PRESC_STAGES = 12;
   // Widths of internal counters
   localparam int PERIOD_W = 8;
   localparam int SETTLE_W = 17;

   // Ratio select encodings
   typedef enum logic [1:0] {
      CDP_DIV_1 = 2'h0,
      CDP_DIV_2 = 2'h1,
      CDP_DIV_4 = 2'h2,
      CDP_DIV_8 = 2'h3
   } cdp_ratio_t;

   // Software write to the division control register
   typedef struct packed {
      logic en;
      logic [7:0] data;
   } cdp_dcr_wr_t;

   // Clock output pin controls
   typedef struct packed {
      logic chip_mode_en;
      logic clock_output_stop;
   } cdp_pin_ctl_t;
endpackage : cdp_pkg

// ===== cdp_prescaler.sv
// Prescaler chain turning system clock ticks into divided module clock enables
`timescale 1ns/1ps
module cdp_prescaler #(
   parameter int STAGES = cdp_pkg::PRESC_STAGES
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sys_tick,
   output logic [STAGES-1:0] presc_tick
);
   typedef struct packed {
      logic [STAGES-1:0] cnt;
      logic [STAGES-1:0] tick;
   } cdp_presc_state_t;

   cdp_presc_state_t s_q;
   cdp_presc_state_t s_d;
   logic [STAGES-1:0] tap;

   // Tap k fires once every 2^(k+1) system clock ticks
   for (genvar k = 0; k < STAGES; k++) begin : g_tap
      assign tap[k] = sys_tick & (&s_q.cnt[k:0]);
   end

   // Free-running count of system ticks
   always_comb begin
      s_d = s_q;
      s_d.tick = tap;
      if (sys_tick) begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign presc_tick = s_q.tick;
endmodule : cdp_prescaler

// ===== cdp_top.sv
// Clock pulse generator: duty adjustment, ratio divider, clock pin and prescalers
// Summary of operation
// - Divide adjusted clock by 1, 2, 4, 8
// - Prescalers give module clocks /2 to /4096
// - Divider counts pin-level rises; only /1 passes duty-adjusted clock
// - Ratio changes live, affects clock and pin
// - System clock feeds pin and prescalers
// - Pin gated by chip mode and stop bit
// - Pin clock shown only after 500 us settling
// - Duty adjust only at 5 MHz or more
// - Ratio field two bits, upper six read one
// - Register reset by reset and hardware standby
`timescale 1ns/1ps
module cdp_top #(
   parameter int SETTLE_CYCLES = cdp_pkg::EXT_CLOCK_SETTLE_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clock_input_pin,
   input wire cdp_pkg::cdp_dcr_wr_t dcr_wr,
   input wire logic hw_standby,
   input wire cdp_pkg::cdp_pin_ctl_t pin_ctl,
   output logic [7:0] dcr_rd_data,
   output logic sys_clk,
   output logic sys_tick,
   output logic [cdp_pkg::PRESC_STAGES-1:0] presc_tick,
   output logic clock_stable,
   output logic clk_pin_o,
   output logic clk_pin_oe_n
);
   localparam int PW = cdp_pkg::PERIOD_W;
   localparam int SW = cdp_pkg::SETTLE_W;
   localparam logic [PW-1:0] DUTY_MAX = PW'(cdp_pkg::DUTY_MAX_PERIOD_CYC);
   localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYCLES - 1);

   typedef struct packed {
      logic [2:0] sync;
      logic lvl;
      logic [PW-1:0] per_cnt;
      logic [PW-1:0] per;
      logic adj;
      logic [2:0] div_cnt;
      cdp_pkg::cdp_ratio_t ratio_act;
      logic [7:0] dcr;
      logic sys_clk;
      logic sys_tick;
      logic seen;
      logic [SW-1:0] settle_cnt;
      logic stable;
      logic pin_o;
      logic pin_oe_n;
   } cdp_state_t;

   cdp_state_t s_q;
   cdp_state_t s_d;

   always_comb begin
      logic rise;
      logic duty_en;
      logic [2:0] mask;
      logic [2:0] nxt;
      logic boundary;
      logic drive;
      s_d = s_q;
      rise = 1'b0;
      duty_en = 1'b0;
      mask = 3'h0;
      nxt = 3'h0;
      boundary = 1'b0;
      drive = 1'b0;

      // Pin crosses three flops; level moves once second and third agree
      s_d.sync = {s_q.sync[1:0], clock_input_pin};
      if (s_q.sync[1] == s_q.sync[2]) begin
         s_d.lvl = s_q.sync[2];
      end
      rise = s_d.lvl & ~s_q.lvl;

      // Measure the oscillator period, saturating for slow inputs
      if (rise) begin
         s_d.per = s_q.per_cnt + 1'b1;
         s_d.per_cnt = '0;
      end else if (s_q.per_cnt != '1) begin
         s_d.per_cnt = s_q.per_cnt + 1'b1;
      end

      // Duty adjustment rebuilds a half-period high phase
      duty_en = (s_q.per != '0) && (s_q.per <= DUTY_MAX);
      if (!duty_en) begin
         s_d.adj = s_d.lvl;
      end else if (rise) begin
         s_d.adj = 1'b1;
      end else if (s_q.per_cnt + 1'b1 >= (s_q.per >> 1)) begin
         s_d.adj = 1'b0;
      end

      // Divider counts rising edges of the synchronised pin level, not edges of adj
      case (s_q.ratio_act)
         cdp_pkg::CDP_DIV_1: mask = 3'h0;
         cdp_pkg::CDP_DIV_2: mask = 3'h1;
         cdp_pkg::CDP_DIV_4: mask = 3'h3;
         cdp_pkg::CDP_DIV_8: mask = 3'h7;
         default: mask = 3'h0;
      endcase
      nxt = s_q.div_cnt + 3'h1;
      boundary = rise && ((nxt & mask) == 3'h0);
      s_d.sys_tick = boundary;
      if (boundary) begin
         // New ratio lands only where a full high phase starts
         s_d.div_cnt = 3'h0;
         s_d.ratio_act = cdp_pkg::cdp_ratio_t'(
            s_q.dcr[cdp_pkg::DCR_RATIO_LSB +: cdp_pkg::DCR_RATIO_W]);
      end else if (rise) begin
         s_d.div_cnt = nxt & mask;
      end
      case (s_d.ratio_act)
         cdp_pkg::CDP_DIV_1: s_d.sys_clk = s_d.adj;
         cdp_pkg::CDP_DIV_2: s_d.sys_clk = ~s_d.div_cnt[0];
         cdp_pkg::CDP_DIV_4: s_d.sys_clk = ~s_d.div_cnt[1];
         cdp_pkg::CDP_DIV_8: s_d.sys_clk = ~s_d.div_cnt[2];
         default: s_d.sys_clk = s_d.adj;
      endcase

      // Register write; upper bits are forced to one; soft standby keeps it
      if (hw_standby) begin
         s_d.dcr = cdp_pkg::DCR_RESET;
      end else if (dcr_wr.en) begin
         s_d.dcr = dcr_wr.data | cdp_pkg::DCR_FIXED_ONES;
      end

      // Settling count starts at the first oscillator edge
      if (rise) begin
         s_d.seen = 1'b1;
      end
      if (s_q.seen && !s_q.stable) begin
         if (s_q.settle_cnt == SETTLE_LAST) begin
            s_d.stable = 1'b1;
         end else begin
            s_d.settle_cnt = s_q.settle_cnt + 1'b1;
         end
      end

      // Pin carries the system clock only when mode allows and not stopped
      drive = pin_ctl.chip_mode_en & ~pin_ctl.clock_output_stop;
      s_d.pin_oe_n = ~drive;
      // Held low until settled so outside logic never sees a runt
      s_d.pin_o = drive & s_d.stable & s_d.sys_clk;
   end

   // Synchronous reset; settling count restarts after release instead of reset being held by the outside
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.dcr <= cdp_pkg::DCR_RESET;
         s_q.ratio_act <= cdp_pkg::CDP_DIV_1;
         s_q.pin_oe_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Divided module clock enables
   cdp_prescaler #(
      .STAGES(cdp_pkg::PRESC_STAGES)
   ) u_presc (
      .core_clk(core_clk),
      .rst(rst),
      .sys_tick(s_q.sys_tick),
      .presc_tick(presc_tick)
   );

   assign dcr_rd_data = s_q.dcr;
   assign sys_clk = s_q.sys_clk;
   assign sys_tick = s_q.sys_tick;
   assign clock_stable = s_q.stable;
   assign clk_pin_o = s_q.pin_o;
   assign clk_pin_oe_n = s_q.pin_oe_n;
endmodule : cdp_top

// ===== cdp_osc_model.sv
// Oscillator source with a lopsided duty cycle
`timescale 1ns/1ps
module cdp_osc_model #(
   parameter int HI_NS = 16,
   parameter int LO_NS = 64,
   parameter int HI_SLOW_NS = 80,
   parameter int LO_SLOW_NS = 320
) (
   input wire logic slow,
   output logic osc
);
   // Free running; offset so edges never meet core_clk edges
   initial begin
      osc = 1'b0;
      #3;
      forever begin
         // Slow mode sits below the duty adjustment threshold
         osc = 1'b1;
         #(slow ? HI_SLOW_NS : HI_NS);
         osc = 1'b0;
         #(slow ? LO_SLOW_NS : LO_NS);
      end
   end
endmodule : cdp_osc_model

// ===== cdp_top_props.sv
// Port checker for the clock divider and prescaler
`timescale 1ns/1ps
module cdp_props (
   input wire logic core_clk,
   input wire logic rst,
   input wire cdp_pkg::cdp_dcr_wr_t dcr_wr,
   input wire logic hw_standby,
   input wire cdp_pkg::cdp_pin_ctl_t pin_ctl,
   input wire logic [7:0] dcr_rd_data,
   input wire logic sys_clk,
   input wire logic sys_tick,
   input wire logic [cdp_pkg::PRESC_STAGES-1:0] presc_tick,
   input wire logic clock_stable,
   input wire logic clk_pin_o,
   input wire logic clk_pin_oe_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_oe; !$past(rst) |-> clk_pin_oe_n == !$past(pin_ctl == 2'h2); endproperty
   a_oe: assert property (p_oe) else $error("pin enable wrong");
   property p_pin; clk_pin_o |-> clock_stable; endproperty
   a_pin: assert property (p_pin) else $error("pin clock before settling");
   property p_stab; clock_stable |=> clock_stable; endproperty
   a_stab: assert property (p_stab) else $error("stable dropped");
   property p_ones; dcr_rd_data[7:2] == 6'h3f; endproperty
   a_ones: assert property (p_ones) else $error("upper bits not one");
   property p_wr; dcr_wr.en && !hw_standby |=> dcr_rd_data[1:0] == $past(dcr_wr.data[1:0]);
   endproperty
   a_wr: assert property (p_wr) else $error("ratio not written");
   property p_hw; hw_standby |=> dcr_rd_data == 8'hfc; endproperty
   a_hw: assert property (p_hw) else $error("standby did not reload");
   property p_tick; sys_tick == $rose(sys_clk); endproperty
   a_tick: assert property (p_tick) else $error("tick not at clock rise");
   property p_gap; sys_tick |=> !sys_tick [*4]; endproperty
   a_gap: assert property (p_gap) else $error("short clock phase");
   property p_pre; |presc_tick |-> $past(sys_tick); endproperty
   a_pre: assert property (p_pre) else $error("prescaler off tick");
   c_wr: cover property (dcr_wr.en ##1 sys_tick);
   c_pin: cover property (clk_pin_o);
   c_pre: cover property (presc_tick[2]);
endmodule : cdp_props
bind cdp_top cdp_props u_cdp_props (.core_clk(core_clk), .rst(rst), .dcr_wr(dcr_wr),
   .hw_standby(hw_standby), .pin_ctl(pin_ctl), .dcr_rd_data(dcr_rd_data), .sys_clk(sys_clk),
   .sys_tick(sys_tick), .presc_tick(presc_tick), .clock_stable(clock_stable),
   .clk_pin_o(clk_pin_o), .clk_pin_oe_n(clk_pin_oe_n));

// ===== test_clock_divider_prescaler.sv
// Self-checking bench for the clock divider and prescaler
`timescale 1ns/1ps
module test_clock_divider_prescaler;
   logic core_clk = 1'b0, rst = 1'b1, hw_standby = 1'b0, osc, sys_clk, sys_tick;
   logic clock_stable, clk_pin_o, clk_pin_oe_n;
   logic slow = 1'b0;
   logic [7:0] dcr_rd_data;
   logic [11:0] presc_tick;
   cdp_pkg::cdp_dcr_wr_t dcr_wr = '0;
   cdp_pkg::cdp_pin_ctl_t pin_ctl = 2'h2;
   int miscompares = 0, n_checks = 0, cyc = 0, a, b;
   initial forever #4 core_clk = ~core_clk;
   cdp_osc_model u_cdp_osc_model (.slow(slow), .osc(osc));
   // Short settling count keeps the run brief
   cdp_top #(.SETTLE_CYCLES(20)) u_cdp_top (.core_clk(core_clk), .rst(rst),
      .clock_input_pin(osc), .dcr_wr(dcr_wr), .hw_standby(hw_standby), .pin_ctl(pin_ctl),
      .dcr_rd_data(dcr_rd_data), .sys_clk(sys_clk), .sys_tick(sys_tick),
      .presc_tick(presc_tick), .clock_stable(clock_stable), .clk_pin_o(clk_pin_o),
      .clk_pin_oe_n(clk_pin_oe_n));
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Inputs move and outputs are read 1 ns after the edge
   task step(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : step
   task wr(input logic [7:0] d);
      dcr_wr = {1'b1, d};
      step(1);
      dcr_wr.en = 1'b0;
      // Idle edge so a following write never retoggles en in one step
      step(1);
   endtask : wr
   // Count cycles to the next tick, and sys_clk high time, bounded
   task period;
      a = 0;
      b = 0;
      do begin
         b += sys_clk;
         step(1);
         a++;
      end while (sys_tick !== 1'b1 && a < 200);
   endtask : period
   task t_ratio;
      for (int r = 0; r < 4; r++) begin
         wr({6'h00, 2'(r)});
         repeat (3) period;
         check(dcr_rd_data, {6'h3f, 2'(r)});
         period;
         check(8'(a), 8'(10 << r));
         if (r == 0) check(8'(b inside {[4:6]}), 8'h01);
         else check(8'(b), 8'(5 << r));
      end
   endtask : t_ratio
   task t_presc;
      wr(8'h00);
      repeat (3) period;
      a = 0;
      b = 0;
      repeat (80) begin
         step(1);
         a += presc_tick[0];
         b += presc_tick[2];
      end
      check(8'(a), 8'h04);
      check(8'(b), 8'h01);
   endtask : t_presc
   // A write in hardware standby loses to the reload
   task t_hwsb;
      wr(8'h03);
      hw_standby = 1'b1;
      wr(8'h01);
      step(1);
      check(dcr_rd_data, 8'hfc);
      hw_standby = 1'b0;
   endtask : t_hwsb
   task t_pin;
      check(8'(clock_stable), 8'h01);
      for (int m = 0; m < 4; m++) begin
         pin_ctl = 2'(m);
         step(2);
         check(8'(clk_pin_oe_n), 8'(m != 2));
      end
      pin_ctl = 2'h2;
      b = 0;
      // Long enough to span many /1 periods; the standby reload replaced the 8'h03 write before it took effect
      repeat (100) begin
         step(1);
         b += clk_pin_o;
      end
      check(8'(b != 0), 8'h01);
   endtask : t_pin
   // Mid-run reset reloads the register and restarts settling
   task t_rst;
      wr(8'h02);
      rst = 1'b1;
      step(2);
      check(dcr_rd_data, 8'hfc);
      check(8'(clk_pin_oe_n), 8'h01);
      rst = 1'b0;
      b = 0;
      repeat (15) begin
         step(1);
         b += clk_pin_o;
      end
      check(8'(b), 8'h00);
      check(8'(clock_stable), 8'h00);
      step(40);
      check(8'(clock_stable), 8'h01);
   endtask : t_rst
   // Slow input: duty adjustment stays off, sys_clk follows the pin
   task t_slow;
      slow = 1'b1;
      repeat (3) period;
      period;
      check(8'(a), 8'h32);
      check(8'(b), 8'h0a);
   endtask : t_slow
   task end_of_test;
      $display("Checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test
   // Hang guard, far above the expected run length
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test;
      end
   end
   initial begin
      step(6);
      // Settle counter restarts at release, standing in for the long reset
      rst = 1'b0;
      check(dcr_rd_data, 8'hfc);
      check(8'(clk_pin_o), 8'h00);
      t_ratio;
      t_presc;
      t_hwsb;
      t_pin;
      t_rst;
      t_slow;
      end_of_test;
   end
endmodule : test_clock_divider_prescaler
